// file: clock_timer.v
// Clock selection, prescalers, base timer, timer1 and their APB registers.
`include "clock_timer_map.vh"
module clock_timer (
   input wire CLOCK,
   input wire RESET,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [13:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   input wire RC_TICK,
   input wire CRYSTAL_TICK,
   input wire EXTERNAL_EVENT_INPUT,
   output reg SYSTEM_CLOCK_SELECT,
   output reg RC_ENABLE,
   output reg CRYSTAL_ENABLE,
   output reg CRYSTAL_NORMAL_DRIVE,
   output reg WAIT1_MODE,
   output reg SWITCH_BUSY,
   output reg BASE_TIMER_IRQ_FLAG,
   output reg TIMER1_IRQ_FLAG,
   output reg IRQ
);
   // The oscillators are modelled as tick inputs, one pulse per cycle.
   wire rc_rise;
   wire crystal_rise;
   wire event_rise;
   edge_sync u_rc_sync (.clk(CLOCK), .rst(RESET), .din(RC_TICK),
      .rise(rc_rise));
   edge_sync u_xtal_sync (.clk(CLOCK), .rst(RESET), .din(CRYSTAL_TICK),
      .rise(crystal_rise));
   edge_sync u_evt_sync (.clk(CLOCK), .rst(RESET),
      .din(EXTERNAL_EVENT_INPUT), .rise(event_rise));

   reg [7:0] system_control;
   reg [3:0] base_timer_mode;
   reg prescaler_enable;
   reg event_source_select;
   reg [4:0] timer1_mode;
   reg [7:0] timer1_count;
   reg [7:0] base_timer_count;
   reg [7:0] interrupt_enable;
   reg [2:0] event_status;
   reg [2:0] event_enable;
   reg clock_select;
   reg [8:0] warmup_count;

   // A write lands at the edge where the master sees PREADY high, so a
   // transfer that is abandoned before its answer changes nothing.
   wire apb_write = PSEL & PENABLE & PWRITE & PREADY;
   wire apb_read = PSEL & PENABLE & ~PWRITE & ~PREADY;
   wire [11:0] index = PADDR[13:2];
   wire wr_prescaler = apb_write & (index == `IDX_PRESCALER_CONTROL);
   wire wr_timer1_count = apb_write & (index == `IDX_TIMER1_COUNT);
   wire wr_irq = apb_write & (index == `IDX_INTERRUPT_REQUEST);
   wire wr_clr = apb_write & (index == `IDX_EVENT_CLEAR);
   wire crystal_run = ~system_control[`SC_CRYSTAL_STOP];
   wire rc_run = ~system_control[`SC_RC_STOP];

   // System clock source, selected by clock_select after warm-up.
   wire selected_tick = clock_select ? crystal_rise & crystal_run
      : rc_rise & rc_run;
   wire target_tick = system_control[`SC_CLOCK_SELECT] ?
      crystal_rise & crystal_run : rc_rise & rc_run;
   wire switch_pending = system_control[`SC_CLOCK_SELECT] != clock_select;
   wire [8:0] warmup_len = system_control[`SC_WARMUP_SKIP] ?
      `WARMUP_SHORT_CYCLES : `WARMUP_LONG_CYCLES;
   wire switch_done = switch_pending & target_tick &
      (warmup_count == warmup_len - 9'd1);

   // The new source is counted in its own cycles, so a stopped target
   // oscillator holds the switch off rather than selecting a dead clock.
   always @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         clock_select <= 1'b0;
         warmup_count <= 9'd0;
      end else if (!switch_pending) begin
         warmup_count <= 9'd0;
      end else if (switch_done) begin
         clock_select <= system_control[`SC_CLOCK_SELECT];
         warmup_count <= 9'd0;
      end else if (target_tick) begin
         warmup_count <= warmup_count + 9'd1;
      end
   end

   // First prescaler input: system clock or external events.
   wire prescaler_input_clock = event_source_select ? event_rise
      : selected_tick;
   wire main_step = prescaler_input_clock & prescaler_enable;
   wire [7:0] main_count;
   wire [7:0] main_carry;
   tap_counter u_main_prescaler (.clk(CLOCK), .rst(RESET),
      .clear(wr_prescaler & PWDATA[`PCTL_RESET]), .step(main_step),
      .count(main_count), .carry(main_carry));
   wire [7:0] crystal_count;
   wire [7:0] crystal_carry;
   tap_counter u_crystal_prescaler (.clk(CLOCK), .rst(RESET),
      .clear(1'b0), .step(crystal_rise & crystal_run),
      .count(crystal_count), .carry(crystal_carry));

   // Tap i divides by 2^(i+1): bit 7 is /256.
   reg base_tick;
   always @* begin
      if (base_timer_mode[`BASE_MODE_CRYSTAL]) begin
         case (base_timer_mode[1:0])
            2'b00: base_tick = crystal_carry[7];
            2'b01: base_tick = crystal_carry[5];
            2'b10: base_tick = crystal_carry[3];
            default: base_tick = crystal_carry[1];
         endcase
      end else begin
         case (base_timer_mode[1:0])
            2'b00: base_tick = main_carry[7];
            2'b01: base_tick = main_carry[4];
            2'b10: base_tick = main_carry[2];
            default: base_tick = main_carry[0];
         endcase
      end
   end

   reg timer1_tick;
   always @* begin
      if (timer1_mode[`TIMER1_MODE_CRYSTAL]) begin
         case (timer1_mode[1:0])
            2'b00: timer1_tick = crystal_carry[7];
            2'b01: timer1_tick = crystal_carry[6];
            2'b10: timer1_tick = crystal_carry[5];
            default: timer1_tick = crystal_carry[4];
         endcase
      end else begin
         case (timer1_mode[1:0])
            2'b00: timer1_tick = main_carry[7];
            2'b01: timer1_tick = main_carry[4];
            2'b10: timer1_tick = main_carry[2];
            default: timer1_tick = main_carry[0];
         endcase
      end
   end

   // In event mode with /256 the rise of prescaler bit 7 (7F to 80) clocks timer1, giving
   // a 16-bit event count of timer1_count and the prescaler.
   wire base_wrap = base_tick & (base_timer_count == 8'hFF);
   wire t1_wrap = timer1_tick & (timer1_count == 8'hFF);

   always @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         base_timer_count <= 8'h00;
         timer1_count <= 8'h00;
      end else begin
         if (base_tick) begin
            base_timer_count <= base_timer_count + 8'h01;
         end
         if (wr_timer1_count) begin
            timer1_count <= PWDATA[7:0];
         end else if (timer1_tick) begin
            timer1_count <= timer1_count + 8'h01;
         end
      end
   end

   // Register writes and sticky flags; a set in the clear cycle wins.
   always @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         system_control <= `RESET_BYTE;
         base_timer_mode <= 4'h0;
         prescaler_enable <= 1'b0;
         event_source_select <= 1'b0;
         timer1_mode <= 5'h00;
         interrupt_enable <= `RESET_BYTE;
         event_status <= 3'h0;
         event_enable <= 3'h0;
         BASE_TIMER_IRQ_FLAG <= 1'b0;
         TIMER1_IRQ_FLAG <= 1'b0;
      end else begin
         if (apb_write) begin
            case (index)
               `IDX_SYSTEM_CONTROL:
                  system_control <= {PWDATA[7:2], 2'b00};
               `IDX_BASE_TIMER_MODE: base_timer_mode <= PWDATA[3:0];
               `IDX_PRESCALER_CONTROL: begin
                  prescaler_enable <= PWDATA[`PCTL_ENABLE];
                  event_source_select <= PWDATA[`PCTL_SOURCE];
               end
               `IDX_TIMER1_MODE: timer1_mode <= PWDATA[4:0];
               `IDX_INTERRUPT_ENABLE: interrupt_enable <= PWDATA[7:0];
               `IDX_EVENT_ENABLE: event_enable <= PWDATA[2:0];
               default: ;
            endcase
         end
         if (base_wrap) begin
            BASE_TIMER_IRQ_FLAG <= 1'b1;
         end else if (wr_irq) begin
            BASE_TIMER_IRQ_FLAG <= PWDATA[`IRQ_BASE_TIMER];
         end
         if (t1_wrap) begin
            TIMER1_IRQ_FLAG <= 1'b1;
         end else if (wr_irq) begin
            TIMER1_IRQ_FLAG <= PWDATA[`IRQ_TIMER1];
         end
         event_status <= (event_status & ~({3{wr_clr}} & PWDATA[2:0]))
            | {switch_done, t1_wrap, base_wrap};
      end
   end

   // Outputs straight from flip-flops.
   always @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         SYSTEM_CLOCK_SELECT <= 1'b0;
         RC_ENABLE <= 1'b0;
         CRYSTAL_ENABLE <= 1'b0;
         CRYSTAL_NORMAL_DRIVE <= 1'b0;
         WAIT1_MODE <= 1'b0;
         SWITCH_BUSY <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         SYSTEM_CLOCK_SELECT <= clock_select;
         RC_ENABLE <= rc_run;
         CRYSTAL_ENABLE <= crystal_run;
         CRYSTAL_NORMAL_DRIVE <=
            system_control[`SC_CRYSTAL_DRIVE_LOAD];
         WAIT1_MODE <= system_control[`SC_WAIT_MODE];
         SWITCH_BUSY <= switch_pending;
         IRQ <= |(event_status & event_enable);
      end
   end

   // APB slave: one wait state; unmapped and write-only reads give zero.
   reg [7:0] read_byte;
   reg mapped;
   always @* begin
      read_byte = 8'h00;
      mapped = 1'b1;
      case (index)
         `IDX_BASE_TIMER_MODE: read_byte = 8'h00;
         `IDX_PRESCALER_CONTROL: read_byte = ~main_count;
         `IDX_TIMER1_MODE: read_byte = {3'b000, timer1_mode};
         `IDX_TIMER1_COUNT: read_byte = timer1_count;
         `IDX_SYSTEM_CONTROL:
            read_byte = {clock_select, system_control[6:0]};
         `IDX_INTERRUPT_REQUEST: read_byte = {2'b00, BASE_TIMER_IRQ_FLAG,
            1'b0, TIMER1_IRQ_FLAG, 3'b000};
         `IDX_INTERRUPT_ENABLE: read_byte = interrupt_enable;
         `IDX_EVENT_STATUS: read_byte = {5'b00000, event_status};
         `IDX_EVENT_ENABLE: read_byte = {5'b00000, event_enable};
         `IDX_EVENT_CLEAR: read_byte = 8'h00;
         default: mapped = 1'b0;
      endcase
   end

   always @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= PSEL & PENABLE & ~PREADY;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
         if (apb_read) begin
            PRDATA <= {24'h000000, read_byte};
         end
      end
   end
endmodule // clock_timer

// file: clock_timer_map.vh
// Register map, field positions, reset values and timing counts of the clock and timer block.
// Functional notes
// - System clock comes from RC oscillator when clock select is 0, crystal when 1.
// - Every system clock source change runs an oscillator warm-up before switching.
// - Reading clock select returns the source actually in use.
// - Crystal stop bit 5: 1 disables the crystal oscillator, 0 enables it.
// - Crystal drive load bit 4: 1 normal drive, 0 heavy-load drive.
// - Either or both oscillators may run; timers may use either source.
// - Event source bit 5: 0 counts system clock, 1 counts external events.
// - First prescaler is 8 bits and offers four divided taps to timers.
// - Reading prescaler control returns one's complement of first prescaler count.
// - Prescaler control write never loads count; upper bits reset, enable, select.
// - In event mode the first prescaler cascades with timer1 as 16-bit counter.
// - Second prescaler counts crystal clock; halts only on crystal stop or reset.
// - Base timer is 8-bit up counter; wrap from all ones sets its flag.
// - Mode bit 3 clear: stop without enable, else first prescaler /256,/32,/8,/2.
// - Mode bit 3 set: crystal clock /256,/64,/16,/4 regardless of enable.
// - Writing 0 to prescaler enable bit 6 stops the first prescaler clock.
`ifndef CLOCK_TIMER_MAP_VH
`define CLOCK_TIMER_MAP_VH
`define IDX_BASE_TIMER_MODE 12'h021
`define IDX_PRESCALER_CONTROL 12'h023
`define IDX_TIMER1_MODE 12'h026
`define IDX_TIMER1_COUNT 12'h027
`define IDX_SYSTEM_CONTROL 12'h030
`define IDX_INTERRUPT_REQUEST 12'h03C
`define IDX_INTERRUPT_ENABLE 12'h03E
`define IDX_EVENT_STATUS 12'h040
`define IDX_EVENT_ENABLE 12'h041
`define IDX_EVENT_CLEAR 12'h042
`define RESET_BYTE 8'h00
`define SC_CLOCK_SELECT 7
`define SC_RC_STOP 6
`define SC_CRYSTAL_STOP 5
`define SC_CRYSTAL_DRIVE_LOAD 4
`define SC_WARMUP_SKIP 3
`define SC_WAIT_MODE 2
`define PCTL_RESET 7
`define PCTL_ENABLE 6
`define PCTL_SOURCE 5
`define BASE_MODE_CRYSTAL 3
`define TIMER1_MODE_CRYSTAL 3
`define TIMER1_MODE_RELOAD 4
`define IRQ_BASE_TIMER 5
`define IRQ_TIMER1 3
`define EVT_BASE_TIMER 0
`define EVT_TIMER1 1
`define EVT_CLOCK_SWITCH 2
`define WARMUP_SHORT_CYCLES 9'd16
`define WARMUP_LONG_CYCLES 9'd256
`endif

// file: edge_sync.v
// Two-stage synchroniser with a one-cycle rising-edge pulse.
module edge_sync (
   input wire clk,
   input wire rst,
   input wire din,
   output reg rise
);
   reg stage1;
   reg stage2;
   reg stage3;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         rise <= 1'b0;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         rise <= stage2 & ~stage3;
      end
   end
endmodule // edge_sync

// file: tap_counter.v
// Eight-bit counter with clear and enable, also reporting which bits rise.
module tap_counter (
   input wire clk,
   input wire rst,
   input wire clear,
   input wire step,
   output reg [7:0] count,
   output wire [7:0] carry
);
   // Bit i rises on this step when it is zero and all lower bits are ones.
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_carry
         if (i == 0) begin : g_lsb
            assign carry[i] = step & ~count[0];
         end else begin : g_upper
            assign carry[i] = step & (&count[i-1:0]) & ~count[i];
         end
      end
   endgenerate
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 8'h00;
      end else if (clear) begin
         count <= 8'h00;
      end else if (step) begin
         count <= count + 8'h01;
      end
   end
endmodule // tap_counter

// file: clock_timer_assertions.sv
// Bus and control-output checks for the clock and timer block.
module clock_timer_assertions (
   input wire CLOCK,
   input wire RESET,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [13:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire SYSTEM_CLOCK_SELECT,
   input wire RC_ENABLE,
   input wire CRYSTAL_ENABLE,
   input wire CRYSTAL_NORMAL_DRIVE,
   input wire WAIT1_MODE,
   input wire SWITCH_BUSY,
   input wire BASE_TIMER_IRQ_FLAG
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   sequence sys_write;
      PSEL && PENABLE && PREADY && PWRITE && PADDR == 14'h0C0;
   endsequence
   pready_wait_a: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
      else $error("bus answer not in second access cycle");
   pready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   slverr_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   rdata_upper_a: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
      else $error("upper read data not zero");
   rdata_hold_a: assert property ($changed(PRDATA) |-> $past(PSEL && !PWRITE))
      else $error("read data changed without a read");
   rc_enable_a: assert property (sys_write |-> ##2 RC_ENABLE == !$past(PWDATA[6], 2))
      else $error("rc enable does not follow its stop bit");
   crystal_enable_a: assert property (sys_write |-> ##2 CRYSTAL_ENABLE == !$past(PWDATA[5], 2))
      else $error("crystal enable does not follow its stop bit");
   load_wait_a: assert property (sys_write |-> ##2 CRYSTAL_NORMAL_DRIVE ==
         $past(PWDATA[4], 2) && WAIT1_MODE == $past(PWDATA[2], 2))
      else $error("drive or wait mode does not follow its bit");
   select_busy_a: assert property ($changed(SYSTEM_CLOCK_SELECT) |-> $past(SWITCH_BUSY))
      else $error("clock source changed without a pending switch");
   flag_sticky_a: assert property ($fell(BASE_TIMER_IRQ_FLAG) |-> $past(PSEL && PWRITE))
      else $error("base timer flag dropped without a write");
endmodule // clock_timer_assertions

bind clock_timer clock_timer_assertions i_chk (.CLOCK(CLOCK), .RESET(RESET),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SYSTEM_CLOCK_SELECT(SYSTEM_CLOCK_SELECT), .RC_ENABLE(RC_ENABLE),
   .CRYSTAL_ENABLE(CRYSTAL_ENABLE), .WAIT1_MODE(WAIT1_MODE),
   .CRYSTAL_NORMAL_DRIVE(CRYSTAL_NORMAL_DRIVE), .SWITCH_BUSY(SWITCH_BUSY),
   .BASE_TIMER_IRQ_FLAG(BASE_TIMER_IRQ_FLAG));

// file: testbench.sv
// Self-checking bench for the clock and timer block.
`include "clock_timer_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [11:0] idx;
      logic [7:0] wd;
      logic [7:0] rd;
      logic err;
   } row_t;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic rc = 1'b0, xt = 1'b0, ev = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, sel, rc_en, xt_en, drive, wait1, busy, bt_flag, irq;
   wire t1_flag;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] rd;
   logic err;
   row_t rows[7] = '{
      '{`IDX_TIMER1_MODE, 8'h0B, 8'h0B, 1'b0},
      '{`IDX_TIMER1_COUNT, 8'hA5, 8'hA5, 1'b0},
      '{`IDX_INTERRUPT_ENABLE, 8'h28, 8'h28, 1'b0},
      '{`IDX_BASE_TIMER_MODE, 8'h03, 8'h00, 1'b0},
      '{`IDX_SYSTEM_CONTROL, 8'h34, 8'h34, 1'b0},
      '{`IDX_EVENT_ENABLE, 8'h07, 8'h07, 1'b0},
      '{12'h050, 8'hFF, 8'h00, 1'b1}
   };

   always #4 clock = ~clock;

   clock_timer i_dut (.CLOCK(clock), .RESET(reset), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RC_TICK(rc),
      .CRYSTAL_TICK(xt), .EXTERNAL_EVENT_INPUT(ev), .SYSTEM_CLOCK_SELECT(sel),
      .RC_ENABLE(rc_en), .CRYSTAL_ENABLE(xt_en), .CRYSTAL_NORMAL_DRIVE(drive),
      .WAIT1_MODE(wait1), .SWITCH_BUSY(busy), .BASE_TIMER_IRQ_FLAG(bt_flag),
      .TIMER1_IRQ_FLAG(t1_flag), .IRQ(irq));

   task automatic stop_test;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] as_byte(input logic x);
      return {7'h00, x};
   endfunction

   // Two idle edges at the end let registered side effects settle.
   task automatic apb(input logic wr, input logic [11:0] idx,
         input logic [7:0] wd);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd = prdata[7:0];
      err = pslverr;
      if (pready !== 1'b1) n_fail++;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   // Each tick is two cycles high and two low, slow enough for the synchroniser.
   task automatic pulse(input int which, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (2) @(posedge clock);
         if (which == 0) rc <= ~rc;
         else if (which == 1) xt <= ~xt;
         else ev <= ~ev;
      end
      repeat (6) @(posedge clock);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
      check(as_byte(sel), 8'h00);
      check(as_byte(t1_flag), 8'h00);
      apb(0, `IDX_SYSTEM_CONTROL, 8'h00);
      check(rd, 8'h00);
      apb(0, `IDX_PRESCALER_CONTROL, 8'h00);
      check(rd, 8'hFF);
      foreach (rows[i]) begin
         apb(1, rows[i].idx, rows[i].wd);
         check(as_byte(err), as_byte(rows[i].err));
         apb(0, rows[i].idx, 8'h00);
         check(rd, rows[i].rd);
         check(as_byte(err), as_byte(rows[i].err));
      end
      check(as_byte(xt_en), 8'h00);
      check(as_byte(drive), 8'h01);
      check(as_byte(wait1), 8'h01);
      check(as_byte(rc_en), 8'h01);
      apb(1, `IDX_SYSTEM_CONTROL, 8'h80);
      pulse(1, 250);
      check(as_byte(sel), 8'h00);
      apb(0, `IDX_SYSTEM_CONTROL, 8'h00);
      check(rd, 8'h00);
      pulse(1, 20);
      check(as_byte(sel), 8'h01);
      apb(0, `IDX_SYSTEM_CONTROL, 8'h00);
      check(rd, 8'h80);
      check(as_byte(irq), 8'h01);
      apb(1, `IDX_EVENT_CLEAR, 8'h04);
      check(as_byte(irq), 8'h00);
      apb(1, `IDX_SYSTEM_CONTROL, 8'h08);
      pulse(0, 12);
      check(as_byte(sel), 8'h01);
      pulse(0, 6);
      check(as_byte(sel), 8'h00);
      apb(1, `IDX_PRESCALER_CONTROL, 8'hE0);
      apb(1, `IDX_PRESCALER_CONTROL, 8'h60);
      pulse(2, 5);
      apb(0, `IDX_PRESCALER_CONTROL, 8'h00);
      check(rd, 8'hFA);
      apb(1, `IDX_PRESCALER_CONTROL, 8'h20);
      pulse(2, 3);
      apb(0, `IDX_PRESCALER_CONTROL, 8'h00);
      check(rd, 8'hFA);
      apb(1, `IDX_PRESCALER_CONTROL, 8'hA0);
      apb(0, `IDX_PRESCALER_CONTROL, 8'h00);
      check(rd, 8'hFF);
      apb(1, `IDX_PRESCALER_CONTROL, 8'h60);
      pulse(2, 500);
      check(as_byte(bt_flag), 8'h00);
      pulse(2, 20);
      check(as_byte(bt_flag), 8'h01);
      check(as_byte(irq), 8'h01);
      apb(0, `IDX_INTERRUPT_REQUEST, 8'h00);
      check(rd & 8'h20, 8'h20);
      apb(1, `IDX_INTERRUPT_REQUEST, 8'h00);
      apb(1, `IDX_EVENT_CLEAR, 8'h07);
      check(as_byte(bt_flag), 8'h00);
      check(as_byte(irq), 8'h00);
      apb(1, `IDX_BASE_TIMER_MODE, 8'h0F);
      apb(1, `IDX_PRESCALER_CONTROL, 8'h00);
      pulse(1, 960);
      check(as_byte(bt_flag), 8'h00);
      pulse(1, 60);
      check(as_byte(bt_flag), 8'h01);
      stop_test();
   end
endmodule // testbench
